// ==== verilog/hpp_ctrl.sv ====
// host port power and suspend controller top
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
module hpp_ctrl
(
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic CS_N,
	input wire logic [1:0] PORT_OVERCURRENT_IN_N,
	input wire logic [1:0] OC_COMPARATOR,
	output logic [1:0] PORT_POWER_SWITCH_N_O,
	output logic [1:0] PORT_POWER_SWITCH_N_OE_N,
	input wire logic WAKE_REQUEST_IN,
	input wire logic BUS_RESUME_DETECT,
	input wire logic PERIPHERAL_SUSPENDED,
	output logic SUSPEND_IND,
	output logic CLOCK_RUN,
	output logic FULL_SUSPEND
);
	import hpp_pkg::*;

	// ******************************
	// registers and state
	// ******************************
	logic [31:0] control;
	logic [31:0] next_control;
	logic [15:0] hw_config;
	logic [15:0] next_hw_config;
	logic resume_flag;
	logic next_resume_flag;
	logic clock_ready;
	logic next_clock_ready;
	logic susp;
	logic next_susp;
	logic clk_run;
	logic next_clk_run;
	logic full_susp;
	logic next_full_susp;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	hpp_clk_state_t cst;
	hpp_clk_state_t next_cst;
	logic wake_d;
	logic [1:0] oe_n;

	function automatic logic [31:0] set_clear(input logic [31:0] cur, input logic [31:0] clr, input logic [31:0] set);
		set_clear = (cur & ~clr) | set;
	endfunction

	wire logic [1:0] fstate = control[STATE_LSB +: 2];
	wire logic wr_ctrl = WR && (ADDR == ADDR_CONTROL_WR);
	wire logic [1:0] new_fstate = WDATA[STATE_LSB +: 2];
	wire logic wake_rise = WAKE_REQUEST_IN && !wake_d;
	wire logic keep_clock = hw_config[KEEP_CLOCK_BIT];

	// ******************************
	// port power
	// ******************************
	hpp_port_power u_power
	(
		.clk(SYS_CLK),
		.rst_n(NRST),
		.internal_oc_en(hw_config[OC_ENABLE_BIT]),
		.oc_internal(OC_COMPARATOR),
		.port_overcurrent_in_n(PORT_OVERCURRENT_IN_N),
		.switch_oe_n(oe_n)
	);

	// ******************************
	// register file and host state
	// ******************************
	always_comb
	begin
		next_control = control;
		next_hw_config = hw_config;
		next_resume_flag = resume_flag;
		next_clock_ready = clock_ready;
		next_rdata = 32'h0;
		if (wr_ctrl)
			next_control = WDATA;
		if (WR && ADDR == ADDR_HW_CONFIG_WR)
			next_hw_config = WDATA[15:0];
		// write-one-to-clear; a same-cycle event still sets the flag
		if (WR && ADDR == ADDR_INT_STATUS_WR && WDATA[RESUME_BIT])
			next_resume_flag = 1'b0;
		if (WR && ADDR == ADDR_UP_INT_WR && WDATA[CLOCK_READY_BIT])
			next_clock_ready = 1'b0;
		if (fstate == FS_SUSPEND && BUS_RESUME_DETECT && !wr_ctrl)
		begin
			next_control = set_clear(control, 32'h000000c0, {24'h0, FS_RESUME, 6'h0});
			next_resume_flag = 1'b1;
		end
		if (cst == CLK_WAKING && cnt == CNT_W'(WAKE_CYCLES - 1))
			next_clock_ready = 1'b1;
		if (RD)
		begin
			case (ADDR)
				ADDR_CONTROL_RD: next_rdata = control;
				ADDR_INT_STATUS_RD: next_rdata = {25'h0, resume_flag, 6'h0};
				ADDR_HW_CONFIG_RD: next_rdata = {16'h0, hw_config};
				ADDR_UP_INT_RD: next_rdata = {25'h0, clock_ready, 6'h0};
				ADDR_PWR_STATUS_RD: next_rdata = {29'h0, full_susp, clk_run, susp};
				default: next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			control <= CONTROL_RESET;
			hw_config <= HW_CONFIG_RESET;
			resume_flag <= 1'b0;
			clock_ready <= 1'b0;
			rdata <= 32'h0;
		end
		else
		begin
			control <= next_control;
			hw_config <= next_hw_config;
			resume_flag <= next_resume_flag;
			clock_ready <= next_clock_ready;
			rdata <= next_rdata;
		end
	end

	// ******************************
	// suspend and clock sequencing
	// ******************************
	always_comb
	begin
		next_susp = susp;
		next_cst = cst;
		next_cnt = cnt;
		next_clk_run = clk_run;
		if (fstate == FS_SUSPEND)
			next_susp = 1'b1;
		else if (fstate == FS_RESET || fstate == FS_OPERATIONAL)
			next_susp = 1'b0;
		case (cst)
			CLK_RUN:
			begin
				next_clk_run = 1'b1;
				if (fstate == FS_SUSPEND && !keep_clock)
				begin
					next_cst = CLK_STOP_WAIT;
					next_cnt = '0;
				end
			end
			CLK_STOP_WAIT:
			begin
				next_cnt = cnt + 1'b1;
				if (fstate != FS_SUSPEND || keep_clock)
					next_cst = CLK_RUN;
				else if (cnt == CNT_W'(STOP_CYCLES - 1))
				begin
					next_cst = CLK_STOPPED;
					next_clk_run = 1'b0;
				end
			end
			CLK_STOPPED:
			begin
				next_cnt = '0;
				if (fstate != FS_SUSPEND)
					next_cst = CLK_RUN;
				else if (wake_rise)
					next_cst = CLK_WAKING;
				else if (!CS_N)
				begin
					next_cst = CLK_RUN;
					next_clk_run = 1'b1;
				end
			end
			CLK_WAKING:
			begin
				next_cnt = cnt + 1'b1;
				if (cnt == CNT_W'(WAKE_CYCLES - 1))
				begin
					next_cst = CLK_WAKE_HOLD;
					next_clk_run = 1'b1;
					next_cnt = '0;
				end
			end
			CLK_WAKE_HOLD:
			begin
				if (fstate != FS_SUSPEND || !CS_N)
					next_cst = CLK_RUN;
				else if (WAKE_REQUEST_IN)
					next_cnt = '0;
				else if (cnt == CNT_W'(WAKE_LOW_CYCLES))
				begin
					next_cst = CLK_STOPPED;
					next_clk_run = 1'b0;
				end
				else
					next_cnt = cnt + 1'b1;
			end
			default:
				next_cst = CLK_RUN;
		endcase
		next_full_susp = !next_clk_run && PERIPHERAL_SUSPENDED;
	end

	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			susp <= 1'b0;
			cst <= CLK_RUN;
			cnt <= '0;
			clk_run <= 1'b1;
			full_susp <= 1'b0;
			wake_d <= 1'b0;
		end
		else
		begin
			susp <= next_susp;
			cst <= next_cst;
			cnt <= next_cnt;
			clk_run <= next_clk_run;
			full_susp <= next_full_susp;
			wake_d <= WAKE_REQUEST_IN;
		end
	end

	assign PORT_POWER_SWITCH_N_O = 2'h0;
	assign PORT_POWER_SWITCH_N_OE_N = oe_n;
	assign RDATA = rdata;
	assign SUSPEND_IND = susp;
	assign CLOCK_RUN = clk_run;
	assign FULL_SUSPEND = full_susp;
endmodule

// ==== verilog/hpp_pkg.sv ====
// constants, register map and state types for the port power and suspend controller
// Functional notes
// - two active-low open-drain power switch outputs, one per downstream port
// - one overcurrent input per downstream port
// - overcurrent drives switch output high (off), otherwise low (on)
// - internal detector enable resets to 0, selecting external detection
// - suspended state stops 48 MHz clock, pll, crystal, regulator powered down
// - full suspend only when host and peripheral controller both suspended
// - entering bus suspend drives suspend indicator high
// - indicator returns low only when state field selects reset or operational
// - bit 11 clear: clock stops 1.3 ms after suspend; set: keeps running
// - wake pulse in suspend restarts clock and sets clock-ready flag bit 6
// - clock available 160 us after wake input rises in suspend
// - clock kept running while wake input high; software may go operational
// - wake low over 1.14 ms after wake-up stops clock, back to suspend
// - chip-select access during suspend acts as software wake-up
// - bus resume moves host to resume state and sets resume-detected flag
package hpp_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int STOP_DELAY_US10 = 13000;
	localparam int WAKE_UP_US = 160;
	localparam int WAKE_LOW_US100 = 11400;
	localparam int STOP_CYCLES = (CLK_HZ / 10000) * STOP_DELAY_US10 / 1000;
	localparam int WAKE_CYCLES = (CLK_HZ / 1000000) * WAKE_UP_US;
	localparam int WAKE_LOW_CYCLES = (CLK_HZ / 10000) * WAKE_LOW_US100 / 1000;
	localparam int CNT_W = 16;
	localparam logic [7:0] ADDR_CONTROL_RD = 8'h01;
	localparam logic [7:0] ADDR_CONTROL_WR = 8'h81;
	localparam logic [7:0] ADDR_INT_STATUS_RD = 8'h03;
	localparam logic [7:0] ADDR_INT_STATUS_WR = 8'h83;
	localparam logic [7:0] ADDR_HW_CONFIG_RD = 8'h20;
	localparam logic [7:0] ADDR_HW_CONFIG_WR = 8'ha0;
	localparam logic [7:0] ADDR_UP_INT_RD = 8'h24;
	localparam logic [7:0] ADDR_UP_INT_WR = 8'ha4;
	localparam logic [7:0] ADDR_PWR_STATUS_RD = 8'h30;
	localparam int STATE_LSB = 6;
	localparam int RESUME_BIT = 6;
	localparam int OC_ENABLE_BIT = 10;
	localparam int KEEP_CLOCK_BIT = 11;
	localparam int CLOCK_READY_BIT = 6;
	localparam logic [1:0] FS_RESET = 2'h0;
	localparam logic [1:0] FS_RESUME = 2'h1;
	localparam logic [1:0] FS_OPERATIONAL = 2'h2;
	localparam logic [1:0] FS_SUSPEND = 2'h3;
	localparam logic [31:0] CONTROL_RESET = 32'h0;
	localparam logic [15:0] HW_CONFIG_RESET = 16'h0;
	typedef enum logic [2:0] {CLK_RUN, CLK_STOP_WAIT, CLK_STOPPED, CLK_WAKING, CLK_WAKE_HOLD} hpp_clk_state_t;
endpackage

// ==== verilog/hpp_port_power.sv ====
// per-port overcurrent to power switch control
module hpp_port_power
	import hpp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic internal_oc_en,
	input wire logic [1:0] oc_internal,
	input wire logic [1:0] port_overcurrent_in_n,
	output logic [1:0] switch_oe_n
);
	logic [1:0] next_switch_oe_n;

	always_comb
	begin
		// overcurrent releases the pin (oe high) so the pull-up turns the switch off
		// external detector flags are active low and already synchronous
		next_switch_oe_n = internal_oc_en ? oc_internal : ~port_overcurrent_in_n;
	end

	// oe low pulls the pin low (switch on); released high cuts supply through pull-up
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			switch_oe_n <= 2'h0;
		else
			switch_oe_n <= next_switch_oe_n;
	end
endmodule

// ==== tb/hpp_partner.sv ====
// far-side model: port power switches, overcurrent sensors, wake source
module hpp_partner
(
	input wire logic clk,
	input wire logic [1:0] sw_o,
	input wire logic [1:0] sw_oe_n,
	input wire logic [1:0] fault,
	input wire logic wake_cmd,
	output logic [1:0] oc_n = 2'h3,
	output logic wake = 1'b0,
	output logic [1:0] power_on
);
	timeunit 1ns;
	timeprecision 1ns;
	// gate pull-up: a released pin turns the switch off
	assign power_on = ~(sw_oe_n | sw_o);
	// sensor flag follows the fault input, not the power, so cutting power does not make it oscillate
	always @(posedge clk)
	begin
		oc_n <= ~fault;
		wake <= wake_cmd;
	end
endmodule

// ==== tb/hpp_ctrl_asserts.sv ====
// port-level checker for the port power and suspend controller
module hpp_ctrl_chk
(
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic CS_N,
	input wire logic [1:0] PORT_OVERCURRENT_IN_N,
	input wire logic [1:0] OC_COMPARATOR,
	input wire logic [1:0] PORT_POWER_SWITCH_N_O,
	input wire logic [1:0] PORT_POWER_SWITCH_N_OE_N,
	input wire logic WAKE_REQUEST_IN,
	input wire logic PERIPHERAL_SUSPENDED,
	input wire logic SUSPEND_IND,
	input wire logic CLOCK_RUN,
	input wire logic FULL_SUSPEND
);
	logic ocen;
	logic [1:0] st;
	logic [15:0] cnt;
	logic [15:0] wk_cnt;
	logic [15:0] lo_cnt;
	logic [15:0] cs_cnt;
	logic woke;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);
	// cnt saturates so only the first stop after suspend is timed
	always_ff @(posedge SYS_CLK or negedge NRST)
		if (!NRST)
		begin
			ocen <= 1'b0;
			st <= 2'h0;
			cnt <= 16'h0;
			wk_cnt <= 16'h0;
			lo_cnt <= 16'h0;
			cs_cnt <= 16'h0;
			woke <= 1'b0;
		end
		else
		begin
			if (WR && ADDR == 8'ha0)
				ocen <= WDATA[10];
			if (WR && ADDR == 8'h81)
				st <= WDATA[7:6];
			if ($rose(SUSPEND_IND))
				cnt <= 16'h1;
			else if (cnt != 16'h0 && cnt < 16'd40000)
				cnt <= cnt + 16'h1;
			// wake spans are too long for a delay range, so counters time them
			if ($rose(WAKE_REQUEST_IN) && !CLOCK_RUN)
				wk_cnt <= 16'h1;
			else if (CLOCK_RUN)
				wk_cnt <= 16'h0;
			else if (wk_cnt != 16'h0 && wk_cnt < 16'd8000)
				wk_cnt <= wk_cnt + 16'h1;
			// only a clock brought up by the wake pin is timed on release
			if ($rose(CLOCK_RUN) && wk_cnt != 16'h0)
				woke <= 1'b1;
			else if (!CLOCK_RUN || !CS_N || !SUSPEND_IND)
				woke <= 1'b0;
			if ($fell(WAKE_REQUEST_IN) && woke && CLOCK_RUN)
				lo_cnt <= 16'h1;
			else if (!CLOCK_RUN || WAKE_REQUEST_IN || !CS_N || !SUSPEND_IND)
				lo_cnt <= 16'h0;
			else if (lo_cnt != 16'h0 && lo_cnt < 16'd40000)
				lo_cnt <= lo_cnt + 16'h1;
			if (!CS_N && SUSPEND_IND && !CLOCK_RUN && cs_cnt == 16'h0)
				cs_cnt <= 16'h1;
			else if (CLOCK_RUN || !SUSPEND_IND)
				cs_cnt <= 16'h0;
			else if (cs_cnt != 16'h0 && cs_cnt < 16'd8000)
				cs_cnt <= cs_cnt + 16'h1;
		end
	// ************************************
	// assertions
	// ************************************
	oc_ext_a: assert property ((!ocen && $stable(PORT_OVERCURRENT_IN_N))[*3]
		|-> PORT_POWER_SWITCH_N_OE_N == ~PORT_OVERCURRENT_IN_N) else $error("external flag ignored");
	oc_int_a: assert property ((ocen && $stable(OC_COMPARATOR))[*3]
		|-> PORT_POWER_SWITCH_N_OE_N == OC_COMPARATOR) else $error("comparator ignored");
	drain_only_a: assert property (PORT_POWER_SWITCH_N_O == 2'h0) else $error("switch pin driven high");
	susp_set_a: assert property (WR && ADDR == 8'h81 && WDATA[7:6] == 2'h3
		|-> ##[1:3] SUSPEND_IND) else $error("indicator not raised");
	susp_clr_a: assert property ($fell(SUSPEND_IND) |-> st == 2'h0 || st == 2'h2) else $error("indicator dropped");
	clk_stop_a: assert property ($fell(CLOCK_RUN) && cnt < 16'd40000
		|-> cnt >= 16'd32490 && cnt <= 16'd32510) else $error("clock stop time wrong");
	wake_up_a: assert property ($rose(CLOCK_RUN) && wk_cnt != 16'h0
		|-> wk_cnt >= 16'd3995) else $error("wake start too early");
	wake_late_a: assert property (wk_cnt <= 16'd4005) else $error("wake start too late");
	wake_hold_a: assert property (WAKE_REQUEST_IN && CLOCK_RUN |=> CLOCK_RUN) else $error("clock lost");
	wake_low_a: assert property ($fell(CLOCK_RUN) && lo_cnt != 16'h0
		|-> lo_cnt >= 16'd28490) else $error("wake release stop too early");
	release_late_a: assert property (lo_cnt <= 16'd28510) else $error("wake release stop too late");
	cs_wake_a: assert property (cs_cnt <= 16'd4100) else $error("no cs wake");
	full_suspend_a: assert property (FULL_SUSPEND |-> $past(PERIPHERAL_SUSPENDED)) else $error("early full suspend");
	rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("stray read data");
	cover property ($fell(CLOCK_RUN));
	cover property ($rose(WAKE_REQUEST_IN) && !CLOCK_RUN);
	cover property (FULL_SUSPEND);
endmodule

bind hpp_ctrl hpp_ctrl_chk i_hpp_ctrl_chk (.SYS_CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .CS_N,
	.PORT_OVERCURRENT_IN_N, .OC_COMPARATOR, .PORT_POWER_SWITCH_N_O, .PORT_POWER_SWITCH_N_OE_N,
	.WAKE_REQUEST_IN, .PERIPHERAL_SUSPENDED, .SUSPEND_IND, .CLOCK_RUN, .FULL_SUSPEND);

// ==== tb/hpp_ctrl_bench.sv ====
// self-checking bench for the port power and suspend controller
module hpp_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, nrst = 0, wr = 0, rd = 0, cs_n = 1, res = 0, per = 0, wk = 0, rd_d = 0;
	logic [7:0] addr = 0;
	logic [31:0] wdata = 0;
	logic [1:0] flt = 0, cmp = 0;
	logic [31:0] rdata;
	logic [1:0] o, oe, ocn, pw;
	logic wake, susp, crun, full;
	logic [31:0] q[$];
	int error_cnt = 0, total_checks = 0;
	always #20 clk = ~clk;
	hpp_ctrl i_hpp_ctrl (.SYS_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .CS_N(cs_n), .PORT_OVERCURRENT_IN_N(ocn), .OC_COMPARATOR(cmp),
		.PORT_POWER_SWITCH_N_O(o), .PORT_POWER_SWITCH_N_OE_N(oe), .WAKE_REQUEST_IN(wake),
		.BUS_RESUME_DETECT(res), .PERIPHERAL_SUSPENDED(per), .SUSPEND_IND(susp), .CLOCK_RUN(crun),
		.FULL_SUSPEND(full));
	hpp_partner i_hpp_partner (.clk(clk), .sw_o(o), .sw_oe_n(oe), .fault(flt), .wake_cmd(wk),
		.oc_n(ocn), .wake(wake), .power_on(pw));
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// each access leaves an idle cycle so no strobe is set twice in one step
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task rd_reg(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task wait_clk(input logic v, input int n);
		for (int i = 0; i < n && crun !== v; i++)
			@(posedge clk);
		chk(crun, v);
	endtask
	always @(posedge clk)
	begin
		if (rd_d)
			chk(rdata, q.pop_front());
		rd_d <= rd;
	end
	initial
	begin
		#(100000 * 40);
		error_cnt++;
		stop_test;
	end
	initial
	begin
		int r;
		r = $urandom(49);
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd_reg(8'h20, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			if (i == 4)
				wr_reg(8'ha0, 32'h400);
			flt <= 2'($urandom);
			cmp <= 2'($urandom);
			repeat (4) @(posedge clk);
			chk(oe, i < 4 ? flt : cmp);
			chk(pw ^ (i < 4 ? flt : cmp), 32'h3);
		end
		wr_reg(8'ha0, 32'h0);
		$display("test power switching done");
		// wake interrupt enables go in before suspend; the enables live outside this block
		wr_reg(8'ha5, 32'h40);
		wr_reg(8'h84, 32'h40);
		per <= 1'b1;
		wr_reg(8'h81, 32'hc0);
		repeat (3) @(posedge clk);
		chk(susp, 1'b1);
		wait_clk(1'b0, 33000);
		@(posedge clk);
		chk(full, 1'b1);
		rd_reg(8'h30, 32'h5);
		wk <= 1'b1;
		wait_clk(1'b1, 4100);
		rd_reg(8'h24, 32'h40);
		wr_reg(8'ha4, 32'h40);
		rd_reg(8'h24, 32'h0);
		repeat (100) @(posedge clk);
		chk(crun, 1'b1);
		wk <= 1'b0;
		wait_clk(1'b0, 29000);
		chk(susp, 1'b1);
		$display("test wake pin done");
		cs_n <= 1'b0;
		@(posedge clk);
		cs_n <= 1'b1;
		wait_clk(1'b1, 4100);
		wr_reg(8'h81, 32'h80);
		repeat (3) @(posedge clk);
		chk(susp, 1'b0);
		// keep-running mode: the clock must outlast the stop delay in suspend
		wr_reg(8'ha0, 32'h800);
		wr_reg(8'h81, 32'hc0);
		repeat (32550) @(posedge clk);
		chk(crun, 1'b1);
		chk(full, 1'b0);
		res <= 1'b1;
		@(posedge clk);
		res <= 1'b0;
		repeat (2) @(posedge clk);
		rd_reg(8'h01, 32'h40);
		rd_reg(8'h03, 32'h40);
		wr_reg(8'h83, 32'h40);
		rd_reg(8'h03, 32'h0);
		rd_reg(8'hff, 32'h0);
		$display("test wake and resume done");
		stop_test;
	end
endmodule
